// [dprc_pkg.sv]
/*
 * shared constants and carriers for the dual-port RAM port controller.
 * assumes a single 20 MHz clock and one RAM port wired to this controller.
 */
package dprc_pkg;

    // ********************************************
    // widths
    // ********************************************
    localparam int ADDR_W     = 15;
    localparam int DATA_MAX_W = 9;
    localparam int TOKEN_AW   = 3;

    // ********************************************
    // mailbox words and pin idle values
    // ********************************************
    localparam logic [ADDR_W-1:0]     MBOX_RIGHT = 15'h7FFF;
    localparam logic [ADDR_W-1:0]     MBOX_LEFT  = 15'h7FFE;
    localparam logic [ADDR_W-1:0]     ADDR_RST   = 15'h0000;
    localparam logic [DATA_MAX_W-1:0] DATA_RST   = 9'h000;

    // ********************************************
    // timing, in ns and in 50 ns cycles
    // ********************************************
    localparam int CLK_PERIOD_NS     = 50;
    localparam int SYNC_STAGES       = 2;
    localparam int FLAG_SETTLE_NS    = 20;  // flag_from_select_low / flag_from_address_match
    localparam int WRITE_PULSE_NS    = 15;
    localparam int READ_ACCESS_NS    = 20;
    localparam int FLOWTHROUGH_NS    = 30;  // flowthrough_delay
    localparam int SETTLE_CYC = (FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int PULSE_CYC  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC   = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                              + (FLOWTHROUGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;

    // ********************************************
    // carriers
    // ********************************************
    typedef struct packed {
        logic                  write;
        logic                  token;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_MAX_W-1:0] wdata;
    } dprc_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              select_n;
        logic              token_latch_select_n;
        logic              rw_n;
        logic              oe_n;
    } dprc_pins_t;

endpackage

// [dprc_sync.sv]
/*
 * two-flop synchroniser for pin inputs.
 * assumes the inputs are asynchronous levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module dprc_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    // level in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            meta_reg <= RST_VAL;
            q_o      <= RST_VAL;
        end
        else
        begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // dprc_sync

// [dprc_port_ctrl.sv]
/*
 * host-side controller for one port of an asynchronous dual-port RAM with
 * contention flag, mailbox interrupt flag and eight token latches.
 * assumes one 20 MHz clock, a synchronous active-high reset, and that the
 * RAM pins are wired directly; bidirectional data is split into in/out/enable.
 */
`timescale 1ns/1ps
module dprc_port_ctrl #(
    parameter int DATA_W = 9
) (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       srst_i,
    // user request side
    input  wire logic                       req_i,
    input  wire dprc_pkg::dprc_cmd_t        cmd_i,
    input  wire logic                       mbox_irq_en_i,
    output logic                            ready_o,
    output logic                            done_o,
    output logic [DATA_W-1:0]               rdata_o,
    output logic                            contention_o,
    output logic                            mbox_irq_o,
    // ram port pins
    output dprc_pkg::dprc_pins_t            pins_o,
    output logic [DATA_W-1:0]               data_o,
    output logic                            data_oe_o,
    input  wire logic [DATA_W-1:0]          data_i,
    input  wire logic                       busy_n_i,
    input  wire logic                       int_n_i
);
    // ********************************************
    // checks and types
    // ********************************************
    if (DATA_W != 8 && DATA_W != 9)
    begin : g_bad_width
        $error("DATA_W must be 8 or 9");
    end

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_SETUP = 6'b000010,
        S_ARB   = 6'b000100,
        S_WRITE = 6'b001000,
        S_READ  = 6'b010000,
        S_END   = 6'b100000
    } dprc_state_t;

    localparam logic [3:0] SETTLE_CNT = 4'(dprc_pkg::SETTLE_CYC);
    localparam logic [3:0] PULSE_CNT  = 4'(dprc_pkg::PULSE_CYC);
    localparam logic [3:0] READ_CNT   = 4'(dprc_pkg::READ_CYC);

    dprc_state_t          state_reg;
    logic [3:0]           cnt_reg;
    dprc_pkg::dprc_cmd_t  cmd_reg;
    logic [DATA_W-1:0]    data_s;
    logic                 busy_s;
    logic                 int_s;

    // ********************************************
    // pin synchronisers
    // ********************************************
    dprc_sync #(.W(DATA_W), .RST_VAL('0)) u_sync_data (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .d_i     (data_i),
        .q_o     (data_s)
    );

    dprc_sync #(.W(2), .RST_VAL(2'h3)) u_sync_flags (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .d_i     ({busy_n_i, int_n_i}),
        .q_o     ({busy_s, int_s})
    );

    // ********************************************
    // decode
    // ********************************************
    wire                        cnt_zero  = (cnt_reg == 4'h0);
    wire                        take_req  = req_i && ready_o;
    // token accesses carry only the latch number; upper lines held low
    wire [dprc_pkg::ADDR_W-1:0] pin_addr  = cmd_i.token ?
        {{(dprc_pkg::ADDR_W-dprc_pkg::TOKEN_AW){1'b0}}, cmd_i.addr[dprc_pkg::TOKEN_AW-1:0]}
        : cmd_i.addr;
    // token write drives only bit zero meaningfully
    wire [DATA_W-1:0]           wr_word   = cmd_reg.token ?
        {{(DATA_W-1){1'b0}}, cmd_reg.wdata[0]} : cmd_reg.wdata[DATA_W-1:0];
    // a token access has no address arbitration to wait on
    wire                        may_write = busy_s || cmd_reg.token;

    // ********************************************
    // sequencer
    // ********************************************
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg    <= S_IDLE;
            cnt_reg      <= 4'h0;
            cmd_reg      <= '0;
            ready_o      <= 1'b1;
            done_o       <= 1'b0;
            rdata_o      <= '0;
            contention_o <= 1'b0;
            pins_o       <= '{addr: dprc_pkg::ADDR_RST, select_n: 1'b1,
                              token_latch_select_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1};
            data_o       <= '0;
            data_oe_o    <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (take_req)
                    begin
                        cmd_reg     <= cmd_i;
                        ready_o     <= 1'b0;
                        pins_o.addr <= pin_addr;   // only moves while rw_n is high
                        pins_o.rw_n <= 1'b1;
                        state_reg   <= S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    // never both selects at once
                    pins_o.select_n             <= cmd_reg.token;
                    pins_o.token_latch_select_n <= ~cmd_reg.token;
                    pins_o.oe_n                 <= cmd_reg.write;
                    data_oe_o                   <= cmd_reg.write;
                    data_o                      <= wr_word;
                    cnt_reg                     <= SETTLE_CNT;
                    state_reg                   <= S_ARB;
                end
                S_ARB:
                begin
                    if (!cnt_zero)
                    begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                    else if (!cmd_reg.write)
                    begin
                        cnt_reg   <= READ_CNT;
                        state_reg <= S_READ;
                    end
                    else if (may_write)
                    begin
                        // select already low, so the write is rw-controlled
                        pins_o.rw_n <= 1'b0;
                        cnt_reg     <= PULSE_CNT;
                        state_reg   <= S_WRITE;
                    end
                    else
                    begin
                        // lost arbitration: hold off, rw stays high
                        contention_o <= 1'b1;
                    end
                end
                S_WRITE:
                begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1)
                    begin
                        pins_o.rw_n <= 1'b1;
                        state_reg   <= S_END;
                    end
                end
                S_READ:
                begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1)
                    begin
                        rdata_o      <= data_s;
                        contention_o <= ~busy_s;
                        state_reg    <= S_END;
                    end
                end
                S_END:
                begin
                    // the deselect gap also serves as the token update pulse
                    pins_o.select_n             <= 1'b1;
                    pins_o.token_latch_select_n <= 1'b1;
                    pins_o.oe_n                 <= 1'b1;
                    data_oe_o                   <= 1'b0;
                    done_o                      <= 1'b1;
                    ready_o                     <= 1'b1;
                    state_reg                   <= S_IDLE;
                    if (cmd_reg.write && !cmd_reg.token)
                    begin
                        contention_o <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // mailbox interrupt reaches the user only when messaging is enabled
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            mbox_irq_o <= 1'b0;
        end
        else
        begin
            mbox_irq_o <= mbox_irq_en_i && !int_s;
        end
    end

    // ********************************************
    // assertions
    // ********************************************
    sequence write_close_s;
        $rose(pins_o.rw_n) ##1 (pins_o.select_n && pins_o.token_latch_select_n && !data_oe_o);
    endsequence

    sequence read_open_s;
        $fell(pins_o.oe_n) && pins_o.rw_n;
    endsequence

    one_select_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !(!pins_o.select_n && !pins_o.token_latch_select_n))
        else $error("both selects low");

    addr_stable_a: assert property (@(posedge clock_i) disable iff (srst_i)
        $changed(pins_o.addr) |-> pins_o.rw_n && pins_o.select_n)
        else $error("address moved during access");

    read_rw_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !pins_o.oe_n |-> pins_o.rw_n && !data_oe_o)
        else $error("read with rw low or data driven");

    token_addr_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !pins_o.token_latch_select_n |-> (pins_o.addr[dprc_pkg::ADDR_W-1:dprc_pkg::TOKEN_AW] == '0))
        else $error("token access with upper address set");

    write_busy_a: assert property (@(posedge clock_i) disable iff (srst_i)
        $fell(pins_o.rw_n) && !pins_o.select_n |-> $past(busy_s))
        else $error("write started while contention flag low");

    write_end_a: assert property (@(posedge clock_i) disable iff (srst_i)
        $fell(pins_o.rw_n) |=> write_close_s)
        else $error("write not closed in order");

    read_done_a: assert property (@(posedge clock_i) disable iff (srst_i)
        read_open_s |-> ##9 done_o)
        else $error("read did not finish on time");

    read_wait_a: assert property (@(posedge clock_i) disable iff (srst_i)
        read_open_s |=> !pins_o.oe_n [*8])
        else $error("read shortened below flowthrough wait");

    token_data_a: assert property (@(posedge clock_i) disable iff (srst_i)
        data_oe_o && !pins_o.token_latch_select_n |-> (data_o[DATA_W-1:1] == '0))
        else $error("token write drives upper bits");

endmodule // dprc_port_ctrl

// [dprc_ram_model.sv]
/*
 * behavioural model of the dual-port ram, with the controller on the left port.
 * assumes the bench plays the right port through the rem_* strobe and contend_i.
 */
`timescale 1ns/1ps
module dprc_ram_model #(
    parameter int DATA_W = 9
) (
    // left port pins
    input  wire dprc_pkg::dprc_pins_t pins_i,
    input  wire logic [DATA_W-1:0]    data_i,
    output logic      [DATA_W-1:0]    data_o,
    output logic                      busy_n_o,
    output logic                      int_n_o,
    // right port, played by the bench
    input  wire logic                 contend_i,
    input  wire logic                 rem_we_i,
    input  wire logic                 rem_tok_i,
    input  wire logic [14:0]          rem_addr_i,
    input  wire logic [DATA_W-1:0]    rem_data_i,
    output logic                      rint_n_o
);
    logic [DATA_W-1:0] mem [0:32767];
    logic [7:0]        lown;
    logic [7:0]        rown;
    logic [7:0]        lreq;
    logic [7:0]        rreq;
    logic [DATA_W-1:0] tok_q;
    logic [DATA_W-1:0] last;
    logic              wtok;
    wire               arr = !pins_i.select_n && pins_i.token_latch_select_n;
    wire               tok = pins_i.select_n && !pins_i.token_latch_select_n;
    wire               rd  = pins_i.rw_n && !pins_i.oe_n && (arr || tok);
    wire               wr  = (arr || tok) && !pins_i.rw_n;
    wire [2:0]         ti  = pins_i.addr[2:0];

    assign busy_n_o = !(contend_i && arr);
    // a released bus shows the inverse of the last value, so stale data never passes
    assign data_o = rd ? (tok ? tok_q : mem[pins_i.addr]) : ~last;

    initial
    begin
        lown = '0;
        rown = '0;
        lreq = '0;
        rreq = '0;
        int_n_o = 1'b1;
        rint_n_o = 1'b1;
        last = '0;
        tok_q = '1;
    end

    task automatic tok_wr(input logic left, input logic [2:0] i, input logic b);
        if (left)
        begin
            lreq[i] = !b;
            lown[i] = !b && !rown[i];
            if (b)
                rown[i] = rreq[i];
        end
        else
        begin
            rreq[i] = !b;
            rown[i] = !b && !lown[i];
            if (b)
                lown[i] = lreq[i];
        end
    endtask

    always @(data_o or rd)
        if (rd)
            last = data_o;
    always @(negedge pins_i.token_latch_select_n)
        tok_q = {DATA_W{~lown[ti]}};
    always @(posedge wr)
        wtok = tok;
    // commit at the end of the overlap, whichever line ends it
    always @(negedge wr)
        if (wtok)
            tok_wr(1'b1, ti, data_i[0]);
        else
        begin
            mem[pins_i.addr] = data_i;
            if (pins_i.addr == dprc_pkg::MBOX_RIGHT && !contend_i)
                rint_n_o = 1'b0;
        end
    always @(posedge rd)
        if (arr && pins_i.addr == dprc_pkg::MBOX_LEFT && !contend_i)
            int_n_o = 1'b1;
    always @(posedge rem_we_i)
        if (rem_tok_i)
            tok_wr(1'b0, rem_addr_i[2:0], rem_data_i[0]);
        else
        begin
            mem[rem_addr_i] = rem_data_i;
            if (rem_addr_i == dprc_pkg::MBOX_LEFT)
                int_n_o = 1'b0;
        end
endmodule  // dprc_ram_model

// [dprc_port_ctrl_bench.sv]
/*
 * self-checking bench for the dual-port ram port controller.
 * assumes the ram model stands on the pins and the bench plays the right port.
 */
`timescale 1ns/1ps
module dprc_port_ctrl_bench;
    localparam int W = dprc_pkg::DATA_MAX_W;
    typedef struct packed { logic rd; logic cont; logic [W-1:0] data; } dprc_exp_t;

    logic                 clock_i = 1'b0;
    logic                 srst_i;
    logic                 req_i;
    dprc_pkg::dprc_cmd_t  cmd_i;
    logic                 mbox_irq_en_i;
    logic                 contend;
    logic                 rem_we;
    logic                 rem_tok;
    logic [14:0]          rem_addr;
    logic [W-1:0]         rem_data;
    wire                  ready_o;
    wire                  done_o;
    wire [W-1:0]          rdata_o;
    wire                  contention_o;
    wire                  mbox_irq_o;
    dprc_pkg::dprc_pins_t pins;
    wire [W-1:0]          wbus;
    wire                  wbus_oe;
    wire [W-1:0]          rbus;
    wire                  busy_n;
    wire                  int_n;
    wire                  rint_n;
    dprc_exp_t            expq[$];
    int                   num_errors = 0;
    int                   compares = 0;

    always #25 clock_i = ~clock_i;

    dprc_port_ctrl #(.DATA_W(W)) dprc_port_ctrl_i (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i),
        .cmd_i(cmd_i), .mbox_irq_en_i(mbox_irq_en_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .contention_o(contention_o), .mbox_irq_o(mbox_irq_o), .pins_o(pins), .data_o(wbus), .data_oe_o(wbus_oe),
        .data_i(rbus), .busy_n_i(busy_n), .int_n_i(int_n));
    // undriven data pins show the inverse, so a write without enable stores a wrong word
    dprc_ram_model #(.DATA_W(W)) dprc_ram_model_i (.pins_i(pins), .data_i(wbus_oe ? wbus : ~wbus), .data_o(rbus),
        .busy_n_o(busy_n), .int_n_o(int_n), .contend_i(contend), .rem_we_i(rem_we), .rem_tok_i(rem_tok),
        .rem_addr_i(rem_addr), .rem_data_i(rem_data), .rint_n_o(rint_n));

    // ****************************************
    // checking
    // ****************************************
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_data(input logic [W-1:0] got, input logic [W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: read data %h expected %h", $time, got, exp);
        end
    endtask

    always @(negedge clock_i)
        if (done_o === 1'b1)
        begin
            if (expq.size() == 0)
                check_bit(1'b1, 1'b0);
            else if (expq[0].rd)
            begin
                check_data(rdata_o, expq[0].data);
                check_bit(contention_o, expq[0].cont);
            end
            if (expq.size() != 0)
                void'(expq.pop_front());
        end

    // ****************************************
    // stimulus
    // ****************************************
    task automatic op(input logic wr, input logic tk, input logic [14:0] a, input logic [W-1:0] d, input logic c);
        int n;
        n = 0;
        expq.push_back('{!wr, c, d});
        @(posedge clock_i);
        req_i <= 1'b1;
        cmd_i <= '{write: wr, token: tk, addr: a, wdata: d};
        @(posedge clock_i);
        req_i <= 1'b0;
        while (done_o !== 1'b1 && n < 400)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n == 400)
            check_bit(1'b1, 1'b0);
    endtask

    // right port write, data or token
    task automatic rem(input logic tk, input logic [14:0] a, input logic [W-1:0] d);
        @(posedge clock_i);
        rem_tok <= tk;
        rem_addr <= a;
        rem_data <= d;
        rem_we <= 1'b1;
        @(posedge clock_i);
        rem_we <= 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock_i);
        check_bit(1'b1, 1'b0);
        tally_and_finish();
    end

    initial
    begin
        logic [14:0]  a [8];
        logic [W-1:0] d [8];
        logic [14:0]  ta;
        srst_i = 1'b1;
        req_i = 1'b0;
        cmd_i = '0;
        mbox_irq_en_i = 1'b0;
        contend = 1'b0;
        rem_we = 1'b0;
        rem_tok = 1'b0;
        rem_addr = '0;
        rem_data = '0;
        void'($urandom(55));
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            a[i] = {i[2:0], 1'b0, 11'($urandom())};
            d[i] = W'($urandom());
            op(1'b1, 1'b0, a[i], d[i], 1'b0);
        end
        for (int i = 7; i >= 0; i--)
            op(1'b0, 1'b0, a[i], d[i], 1'b0);
        check_bit(mbox_irq_o, 1'b0);
        mbox_irq_en_i <= 1'b1;
        rem(1'b0, dprc_pkg::MBOX_LEFT, 9'h1A5);
        repeat (4) @(posedge clock_i);
        check_bit(mbox_irq_o, 1'b1);
        mbox_irq_en_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check_bit(mbox_irq_o, 1'b0);
        mbox_irq_en_i <= 1'b1;
        op(1'b1, 1'b0, dprc_pkg::MBOX_RIGHT, 9'h05A, 1'b0);
        check_bit(rint_n, 1'b0);
        op(1'b0, 1'b0, dprc_pkg::MBOX_RIGHT, 9'h05A, 1'b0);
        repeat (4) @(posedge clock_i);
        check_bit(mbox_irq_o, 1'b1);
        contend <= 1'b1;
        op(1'b0, 1'b0, dprc_pkg::MBOX_LEFT, 9'h1A5, 1'b1);
        repeat (4) @(posedge clock_i);
        check_bit(mbox_irq_o, 1'b1);
        contend <= 1'b0;
        op(1'b0, 1'b0, dprc_pkg::MBOX_LEFT, 9'h1A5, 1'b0);
        repeat (4) @(posedge clock_i);
        check_bit(mbox_irq_o, 1'b0);
        contend <= 1'b1;
        fork
            op(1'b1, 1'b0, 15'h0123, 9'h0C3, 1'b0);
            begin
                repeat (30) @(posedge clock_i);
                check_bit(pins.rw_n, 1'b1);
                check_bit(ready_o, 1'b0);
                check_bit(contention_o, 1'b1);
                contend <= 1'b0;
            end
        join
        op(1'b0, 1'b0, 15'h0123, 9'h0C3, 1'b0);
        for (int t = 0; t < 8; t++)
        begin
            ta = {12'($urandom()), t[2:0]};
            op(1'b1, 1'b1, ta, 9'h1FE, 1'b0);
            op(1'b0, 1'b1, ta ^ 15'h7FF8, '0, 1'b0);
            op(1'b1, 1'b1, ta, 9'h001, 1'b0);
            op(1'b0, 1'b1, ta, '1, 1'b0);
        end
        rem(1'b1, 15'h0005, '0);
        op(1'b1, 1'b1, 15'h0005, '0, 1'b0);
        op(1'b0, 1'b1, 15'h0005, '1, 1'b0);
        rem(1'b1, 15'h0005, 9'h001);
        op(1'b0, 1'b1, 15'h0005, '0, 1'b0);
        repeat (4) @(posedge clock_i);
        tally_and_finish();
    end
endmodule  // dprc_port_ctrl_bench
